// *** verilog/adcc_defs.vh ***
// What this block does
// R1: Outside world drives about 1100mV high and 100mV low reference inputs.
// R2: After first configuration command, sum both references over 4096 PWM cycles.
// R3: Derive scaled gain and offset from averages and ideal values; readable.
// R4: Compensated result is raw times gain plus offset, on every output.
// R5: No compensated results until 4096 PWM cycles after first configuration.
// R6: Host writes ideal references and configuration before first command.
// R7: Host should not read results during calibration interval.
// R8: Compensation on after reset; control bit 9 set disables it.
// R9: Raise compensation fault when gain or offset is out of range.
// R10: Gain and offset limits are parameters.
`ifndef ADCC_DEFS_VH
`define ADCC_DEFS_VH
// Register word addresses
`define ADCC_A_REF_HIGH    4'h0
`define ADCC_A_REF_LOW     4'h1
`define ADCC_A_SEQ_CTRL    4'h2
`define ADCC_A_CTRL_BITS   4'h3
`define ADCC_A_GAIN        4'h4
`define ADCC_A_OFFSET      4'h5
`define ADCC_A_STATUS      4'h6
`define ADCC_A_IRQ_STAT    4'h7
`define ADCC_A_IRQ_MASK    4'h8
`define ADCC_A_RESULT      4'h9
// Field positions
`define ADCC_CTRL_DIS_BIT  9
`define ADCC_ST_DONE_BIT   0
`define ADCC_ST_FAULT_BIT  1
`define ADCC_ST_BUSY_BIT   2
`define ADCC_IRQ_DONE_BIT  0
`define ADCC_IRQ_FAULT_BIT 1
`define ADCC_IRQ_RES_BIT   2
// Scale and averaging
`define ADCC_GAIN_SHIFT    10
`define ADCC_GAIN_UNITY    16'h0400
`define ADCC_AVG_SHIFT     12
`define ADCC_AVG_COUNT     13'h1000
// Reset values
`define ADCC_REF_HIGH_RST  16'h0000
`define ADCC_REF_LOW_RST   16'h0000
`endif

// *** verilog/adcc_divider.v ***
`timescale 1ns/100ps
// Signed divider: quotient = num / den, restoring, one bit per cycle
module adcc_divider #(
    parameter NW = 28,
    parameter DW = 13
) (
    // Clock and reset
    input  wire                 clock_in,
    input  wire                 nrst_in,
    // Request
    input  wire                 start_in,
    input  wire signed [NW-1:0] num_in,
    input  wire signed [DW-1:0] den_in,
    // Answer
    output reg                  done_out,
    output reg  signed [NW-1:0] quot_out
);
    reg [NW-1:0] n_q;
    reg [NW-1:0] q_q;
    reg [NW:0]   r_q;
    reg [DW-1:0] d_q;
    reg          neg_q;
    reg [5:0]    cnt_q;
    reg          busy_q;
    localparam [5:0] NW_CNT = NW; // Iteration count, one per quotient bit
    wire [NW:0]  r_sh = {r_q[NW-1:0], n_q[NW-1]};
    wire [NW:0]  r_sub = r_sh - {{(NW+1-DW){1'b0}}, d_q};

    // Iterative unsigned division of magnitudes
    always @(posedge clock_in) begin
        if (!nrst_in) begin
            n_q      <= {NW{1'b0}};
            q_q      <= {NW{1'b0}};
            r_q      <= {(NW+1){1'b0}};
            d_q      <= {DW{1'b0}};
            neg_q    <= 1'b0;
            cnt_q    <= 6'h00;
            busy_q   <= 1'b0;
            done_out <= 1'b0;
            quot_out <= {NW{1'b0}};
        end else begin
            done_out <= 1'b0;
            if (start_in) begin
                n_q    <= num_in[NW-1] ? -num_in : num_in;
                d_q    <= den_in[DW-1] ? -den_in : den_in;
                neg_q  <= num_in[NW-1] ^ den_in[DW-1];
                r_q    <= {(NW+1){1'b0}};
                cnt_q  <= NW_CNT;
                busy_q <= 1'b1;
            end else if (busy_q) begin
                n_q <= {n_q[NW-2:0], 1'b0};
                if (!r_sub[NW]) begin
                    r_q <= r_sub;
                    q_q <= {q_q[NW-2:0], 1'b1};
                end else begin
                    r_q <= r_sh;
                    q_q <= {q_q[NW-2:0], 1'b0};
                end
                cnt_q <= cnt_q - 6'h01;
                if (cnt_q == 6'h01) begin
                    busy_q <= 1'b0;
                end
            end else if (cnt_q == 6'h00 && d_q != {DW{1'b0}}) begin
                // Finish: apply sign once, then idle
                quot_out <= neg_q ? -q_q : q_q;
                done_out <= 1'b1;
                d_q      <= {DW{1'b0}};
            end
        end
    end
endmodule // adcc_divider

// *** verilog/adcc_top.v ***
`timescale 1ns/100ps
`include "adcc_defs.vh"
// Two-point A/D gain and offset compensation
module adcc_top #(
    parameter AW        = 12,
    parameter AVG_N     = 4096,
    parameter GAIN_MIN  = 16'sh0300,
    parameter GAIN_MAX  = 16'sh0500,
    parameter OFS_MIN   = -16'sh0100,
    parameter OFS_MAX   = 16'sh0100
) (
    // Clock and reset
    input  wire          clock_in,
    input  wire          nrst_in,
    // Register port
    input  wire [3:0]    addr_in,
    input  wire [15:0]   wdata_in,
    input  wire          wr_in,
    input  wire          rd_in,
    output reg  [15:0]   rdata_out,
    // Converter sequencer
    input  wire          pwm_tick_in,
    input  wire [AW-1:0] high_reference_input_in,
    input  wire [AW-1:0] low_reference_input_in,
    input  wire          raw_valid_in,
    input  wire [AW-1:0] raw_in,
    // Results
    output reg           res_valid_out,
    output reg  [AW-1:0] res_out,
    output reg           fault_out,
    output reg           irq_out
);
    localparam S_IDLE = 5'h01;
    localparam S_ACC  = 5'h02;
    localparam S_DIV  = 5'h04;
    localparam S_WAIT = 5'h08;
    localparam S_RUN  = 5'h10;

    // Saturate a wide signed value to AW bits signed
    function [AW-1:0] sat;
        input signed [31:0] v;
        begin
            if (v > $signed((1 << (AW-1)) - 1))
                sat = {1'b0, {(AW-1){1'b1}}};
            else if (v < -$signed(1 << (AW-1)))
                sat = {1'b1, {(AW-1){1'b0}}};
            else
                sat = v[AW-1:0];
        end
    endfunction

    reg [4:0]         st_q;
    reg signed [15:0] ref_high_q;
    reg signed [15:0] ref_low_q;
    reg [15:0]        ctrl_bits_q;
    reg               seq_ctrl_q;
    reg               started_q;
    reg signed [31:0] sum_h_q;
    reg signed [31:0] sum_l_q;
    reg [12:0]        cnt_q;
    reg signed [15:0] gain_q;
    reg signed [15:0] ofs_q;
    reg signed [15:0] avg_h_q;
    reg signed [15:0] avg_l_q;
    reg               done_q;
    reg [2:0]         irq_st_q;
    reg [2:0]         irq_mask_q;
    reg               div_start_q;
    wire              div_done;
    wire signed [27:0] div_quot;

    // Ideal span scaled, divided by measured span
    wire signed [27:0] num =
        $signed({{12{1'b0}}, 16'h0000}) +
        (($signed({{12{ref_high_q[15]}}, ref_high_q}) -
          $signed({{12{ref_low_q[15]}}, ref_low_q})) <<< `ADCC_GAIN_SHIFT);
    wire signed [15:0] span_w = avg_h_q - avg_l_q;

    adcc_divider #(.NW(28), .DW(13)) u_div (
        .clock_in (clock_in),
        .nrst_in  (nrst_in),
        .start_in (div_start_q),
        .num_in   (num),
        .den_in   (span_w[12:0]),
        .done_out (div_done),
        .quot_out (div_quot)
    );

    // Offset B = ideal_low - K * avg_low, K in 1/1024 units
    wire signed [31:0] kl = $signed(div_quot[15:0]) * avg_l_q;
    wire signed [31:0] ofs_w = $signed({{16{ref_low_q[15]}}, ref_low_q})
                               - (kl >>> `ADCC_GAIN_SHIFT);
    wire signed [15:0] gain_w = div_quot[15:0];
    wire bad_w = (gain_w < GAIN_MIN) || (gain_w > GAIN_MAX) ||
                 (ofs_w < OFS_MIN) || (ofs_w > OFS_MAX) ||
                 (div_quot > 28'sh0007fff) || (div_quot < -28'sh0008000);

    // Y = K*X + B
    wire signed [31:0] corr_w =
        (($signed(gain_q) * $signed({{4{raw_in[AW-1]}}, raw_in}))
         >>> `ADCC_GAIN_SHIFT) + ofs_q;
    wire comp_en = !ctrl_bits_q[`ADCC_CTRL_DIS_BIT];
    wire rd_irq  = rd_in && (addr_in == `ADCC_A_IRQ_STAT);
    wire [2:0] ev = {raw_valid_in, div_done && bad_w, div_done};

    // Calibration sequence
    always @(posedge clock_in) begin
        if (!nrst_in) begin
            st_q        <= S_IDLE;
            started_q   <= 1'b0;
            sum_h_q     <= 32'sh0;
            sum_l_q     <= 32'sh0;
            cnt_q       <= 13'h0000;
            avg_h_q     <= 16'sh0;
            avg_l_q     <= 16'sh0;
            gain_q      <= `ADCC_GAIN_UNITY;
            ofs_q       <= 16'sh0;
            done_q      <= 1'b0;
            fault_out   <= 1'b0;
            div_start_q <= 1'b0;
        end else begin
            div_start_q <= 1'b0;
            case (st_q)
                S_IDLE: begin
                    if (seq_ctrl_q && !started_q) begin // R2
                        started_q <= 1'b1;
                        sum_h_q   <= 32'sh0;
                        sum_l_q   <= 32'sh0;
                        cnt_q     <= 13'h0000;
                        st_q      <= S_ACC;
                    end
                end
                S_ACC: begin
                    if (pwm_tick_in) begin // R2
                        sum_h_q <= sum_h_q +
                            $signed({{20{high_reference_input_in[AW-1]}},
                                     high_reference_input_in});
                        sum_l_q <= sum_l_q +
                            $signed({{20{low_reference_input_in[AW-1]}},
                                     low_reference_input_in});
                        cnt_q   <= cnt_q + 13'h0001;
                        if (cnt_q == AVG_N - 1)
                            st_q <= S_DIV;
                    end
                end
                S_DIV: begin
                    // Average by shift over the sample count
                    avg_h_q     <= sum_h_q[`ADCC_AVG_SHIFT+15:`ADCC_AVG_SHIFT];
                    avg_l_q     <= sum_l_q[`ADCC_AVG_SHIFT+15:`ADCC_AVG_SHIFT];
                    div_start_q <= 1'b1;
                    st_q        <= S_WAIT;
                end
                S_WAIT: begin
                    if (div_done) begin // R3
                        gain_q    <= gain_w;
                        ofs_q     <= ofs_w[15:0];
                        fault_out <= bad_w; // R9 R10
                        done_q    <= 1'b1;
                        st_q      <= S_RUN;
                    end
                end
                S_RUN: st_q <= S_RUN;
                default: st_q <= S_IDLE;
            endcase
        end
    end

    // Result output path
    always @(posedge clock_in) begin
        if (!nrst_in) begin
            res_valid_out <= 1'b0;
            res_out       <= {AW{1'b0}};
        end else begin
            res_valid_out <= raw_valid_in;
            if (!comp_en)
                res_out <= raw_in; // R8
            else if (done_q)
                res_out <= sat(corr_w); // R4 R5
            else
                res_out <= {AW{1'b0}}; // R5
        end
    end

    // Registers, sticky events, interrupt
    always @(posedge clock_in) begin
        if (!nrst_in) begin
            ref_high_q  <= `ADCC_REF_HIGH_RST;
            ref_low_q   <= `ADCC_REF_LOW_RST;
            ctrl_bits_q <= 16'h0000; // R8
            seq_ctrl_q  <= 1'b0;
            irq_st_q    <= 3'h0;
            irq_mask_q  <= 3'h0;
            irq_out     <= 1'b0;
        end else begin
            if (wr_in) begin
                case (addr_in)
                    `ADCC_A_REF_HIGH: ref_high_q <= wdata_in;
                    `ADCC_A_REF_LOW:  ref_low_q <= wdata_in;
                    `ADCC_A_SEQ_CTRL: seq_ctrl_q <= wdata_in[0];
                    `ADCC_A_CTRL_BITS: ctrl_bits_q <= wdata_in; // R8
                    `ADCC_A_IRQ_MASK: irq_mask_q <= wdata_in[2:0];
                    default: ;
                endcase
            end
            // Set wins over the clear by read
            irq_st_q <= (rd_irq ? 3'h0 : irq_st_q) | ev;
            irq_out  <= |(((rd_irq ? 3'h0 : irq_st_q) | ev) & irq_mask_q);
        end
    end

    // Read data, one cycle after strobe
    always @(posedge clock_in) begin
        if (!nrst_in) begin
            rdata_out <= 16'h0000;
        end else if (rd_in) begin
            case (addr_in)
                `ADCC_A_REF_HIGH:  rdata_out <= ref_high_q;
                `ADCC_A_REF_LOW:   rdata_out <= ref_low_q;
                `ADCC_A_SEQ_CTRL:  rdata_out <= {15'h0000, seq_ctrl_q};
                `ADCC_A_CTRL_BITS: rdata_out <= ctrl_bits_q;
                `ADCC_A_GAIN:      rdata_out <= gain_q; // R3
                `ADCC_A_OFFSET:    rdata_out <= ofs_q; // R3
                `ADCC_A_STATUS:    rdata_out <= {13'h0000,
                                      st_q != S_IDLE && !done_q,
                                      fault_out, done_q};
                `ADCC_A_IRQ_STAT:  rdata_out <= {13'h0000, irq_st_q};
                `ADCC_A_IRQ_MASK:  rdata_out <= {13'h0000, irq_mask_q};
                `ADCC_A_RESULT:    rdata_out <= {{4{res_out[AW-1]}}, res_out};
                default:           rdata_out <= 16'h0000;
            endcase
        end else begin
            rdata_out <= 16'h0000;
        end
    end
endmodule // adcc_top

// *** verif/adcc_top_monitor.sv ***
`timescale 1ns/100ps
// Port checks on the compensation block
module adcc_mon #(
    parameter AW    = 12,
    parameter AVG_N = 4096
) (
    // Clock and reset
    input wire          clock_in,
    input wire          nrst_in,
    // Register port
    input wire [3:0]    addr_in,
    input wire [15:0]   wdata_in,
    input wire          wr_in,
    input wire          rd_in,
    input wire [15:0]   rdata_out,
    // Samples and results
    input wire          pwm_tick_in,
    input wire          raw_valid_in,
    input wire [AW-1:0] raw_in,
    input wire          res_valid_out,
    input wire [AW-1:0] res_out,
    input wire          fault_out
);
    reg        run_q;
    reg        dis_q;
    reg [12:0] cnt_q;
    wire       early;
    // Start flag, bypass bit, ticks since start
    always @(posedge clock_in) begin
        if (!nrst_in) begin
            run_q <= 1'b0;
            dis_q <= 1'b0;
            cnt_q <= 13'h0;
        end else begin
            if (wr_in && addr_in == 4'h2 && wdata_in[0])
                run_q <= 1'b1;
            if (wr_in && addr_in == 4'h3)
                dis_q <= wdata_in[9];
            if (run_q && pwm_tick_in && cnt_q < AVG_N)
                cnt_q <= cnt_q + 13'h1;
        end
    end
    assign early = (cnt_q < AVG_N);
    default clocking @(posedge clock_in); endclocking
    default disable iff (!nrst_in);
    sequence gain_rd_s;
        rd_in && addr_in == 4'h4 && early;
    endsequence
    sequence raw_on_s;
        raw_valid_in && !wr_in;
    endsequence
    rd_quiet_a: assert property (!rd_in |=> rdata_out == 16'h0)
        else $error("read data not zero when idle");
    gain_init_a: assert property (gain_rd_s |=> rdata_out == 16'h0400)
        else $error("gain not unity before calibration");
    res_pulse_a: assert property (raw_valid_in |=> res_valid_out)
        else $error("missing result pulse");
    res_idle_a: assert property (!raw_valid_in |=> !res_valid_out)
        else $error("result pulse without sample");
    early_zero_a: assert property (raw_on_s ##0 (early && !dis_q)
        |=> res_out == 0) else $error("result before calibration");
    bypass_raw_a: assert property (raw_on_s ##0 dis_q
        |=> res_out == $past(raw_in)) else $error("bypass not raw");
    fault_early_a: assert property (early |-> !fault_out)
        else $error("fault before calibration");
    fault_hold_a: assert property (fault_out |=> fault_out)
        else $error("fault dropped");
endmodule // adcc_mon
bind adcc_top adcc_mon #(.AW(AW), .AVG_N(AVG_N)) u_adcc_mon (
    .clock_in(clock_in), .nrst_in(nrst_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .pwm_tick_in(pwm_tick_in),
    .raw_valid_in(raw_valid_in), .raw_in(raw_in),
    .res_valid_out(res_valid_out), .res_out(res_out),
    .fault_out(fault_out));

// *** verif/adcc_seq_model.sv ***
`timescale 1ns/100ps
// Sequencer stand-in: PWM tick and reference readings
module adcc_seq_model #(
    parameter [11:0] HI_REF = 12'h708,
    parameter [11:0] LO_REF = 12'h0c8
) (
    // Clock and reset
    input  wire        clock_in,
    input  wire        nrst_in,
    // Sequencer side
    output reg         pwm_tick_out,
    output wire [11:0] high_ref_out,
    output wire [11:0] low_ref_out
);
    // One PWM cycle every two clocks
    always @(posedge clock_in) begin
        pwm_tick_out <= nrst_in ? !pwm_tick_out : 1'b0;
    end
    // Readings valid only at the tick, inverted otherwise
    assign high_ref_out = pwm_tick_out ? HI_REF : ~HI_REF;
    assign low_ref_out  = pwm_tick_out ? LO_REF : ~LO_REF;
endmodule // adcc_seq_model

// *** verif/adcc_top_tb_top.sv ***
`timescale 1ns/100ps
// Self-checking bench for the compensation block
module adcc_top_tb_top;
    reg         clock_in = 1'b0;
    reg         nrst_in = 1'b0;
    reg  [3:0]  addr_in = 4'h0;
    reg  [15:0] wdata_in = 16'h0;
    reg         wr_in = 1'b0;
    reg         rd_in = 1'b0;
    reg         raw_valid_in = 1'b0;
    reg  [11:0] raw_in = 12'h0;
    wire [15:0] rdata_out;
    wire        tick;
    wire [11:0] hi_ref;
    wire [11:0] lo_ref;
    wire        res_valid_out;
    wire [11:0] res_out;
    wire        fault_out;
    wire        irq_out;
    reg  [31:0] rnd = 32'h2112;
    integer     n_fail = 0;
    integer     comparisons = 0;
    integer     g, o, x, y, k;
    always #50 clock_in = ~clock_in;
    adcc_seq_model u_adcc_seq_model (.clock_in(clock_in),
        .nrst_in(nrst_in), .pwm_tick_out(tick),
        .high_ref_out(hi_ref), .low_ref_out(lo_ref));
    adcc_top u_adcc_top (.clock_in(clock_in), .nrst_in(nrst_in),
        .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in),
        .rd_in(rd_in), .rdata_out(rdata_out), .pwm_tick_in(tick),
        .high_reference_input_in(hi_ref),
        .low_reference_input_in(lo_ref), .raw_valid_in(raw_valid_in),
        .raw_in(raw_in), .res_valid_out(res_valid_out),
        .res_out(res_out), .fault_out(fault_out), .irq_out(irq_out));
    // Count one comparison, report a mismatch
    task chk(input [15:0] got, input [15:0] exp);
        begin
            comparisons = comparisons + 1;
            if (got !== exp) begin
                n_fail = n_fail + 1;
                $display("unexpected at %0t: %h vs %h", $time, got, exp);
            end
        end
    endtask
    // Next pseudo-random word
    function [31:0] xorshift(input [31:0] s);
        reg [31:0] t;
        begin
            t = s ^ (s << 13);
            t = t ^ (t >> 17);
            t = t ^ (t << 5);
            xorshift = t;
        end
    endfunction
    // Strobed register write or read
    task bus(input w, input [3:0] a, input [15:0] d);
        begin
            @(posedge clock_in);
            addr_in  <= a;
            wdata_in <= d;
            wr_in    <= w;
            rd_in    <= !w;
            @(posedge clock_in);
            wr_in    <= 1'b0;
            rd_in    <= 1'b0;
            #1;
        end
    endtask
    // Raw sample in, corrected result out
    task raw(input [11:0] xv, input [11:0] e);
        begin
            @(posedge clock_in);
            raw_in       <= xv;
            raw_valid_in <= 1'b1;
            @(posedge clock_in);
            raw_valid_in <= 1'b0;
            #1 chk({res_valid_out, res_out}, {4'h1, e});
        end
    endtask
    // Interrupt level after it settles
    task irq_is(input e);
        begin
            repeat (2) @(posedge clock_in);
            #1 chk({15'h0, irq_out}, {15'h0, e});
        end
    endtask
    // Bounded wait for the interrupt
    task wait_irq;
        begin
            for (k = 0; k < 12000 && irq_out !== 1'b1; k = k + 1)
                @(posedge clock_in);
            #1 chk({15'h0, irq_out}, 16'h1);
            if (irq_out !== 1'b1)
                finish_test;
        end
    endtask
    task finish_test;
        begin
            $display("comparisons %0d mismatches %0d", comparisons, n_fail);
            if (n_fail == 0 && comparisons > 0) begin
                $display("Run complete: PASS");
            end else begin
                $display("Run complete: FAIL");
            end
            $finish;
        end
    endtask
    // Reset, ideal values, start command
    task start(input [15:0] ih, input [15:0] m);
        begin
            @(posedge clock_in);
            nrst_in <= 1'b0;
            repeat (20) @(posedge clock_in);
            nrst_in <= 1'b1;
            bus(1, 4'h0, ih);
            bus(1, 4'h1, 16'h00c8);
            bus(1, 4'h8, m);
            bus(1, 4'h2, 16'h0001);
        end
    endtask
    initial begin
        start(16'h07d0, 16'h0001);
        raw(12'h100, 12'h000);
        bus(0, 4'h4, 0);
        chk(rdata_out, 16'h0400);
        bus(0, 4'h6, 0);
        chk(rdata_out, 16'h0004);
        wait_irq;
        g = (2000 - 200) * 1024 / (1800 - 200);
        o = 200 - g * 200 / 1024;
        bus(0, 4'h4, 0);
        chk(rdata_out, g[15:0]);
        bus(0, 4'h5, 0);
        chk(rdata_out, o[15:0]);
        bus(0, 4'h6, 0);
        chk(rdata_out, 16'h0001);
        bus(0, 4'h7, 0);
        chk(rdata_out, 16'h0005);
        bus(0, 4'h7, 0);
        chk(rdata_out, 16'h0000);
        $display("test calibration done");
        for (k = 0; k < 24; k = k + 1) begin
            rnd = xorshift(rnd);
            x = (rnd % 200) * 8;
            y = g * x / 1024 + o;
            raw(x[11:0], y[11:0]);
        end
        irq_is(1'b0);
        bus(1, 4'h8, 16'h0004);
        irq_is(1'b1);
        bus(0, 4'h7, 0);
        irq_is(1'b0);
        $display("test correction and interrupt done");
        bus(1, 4'h3, 16'h0200);
        raw(12'h5a8, 12'h5a8);
        bus(1, 4'h3, 16'h0000);
        y = g * 1448 / 1024 + o;
        raw(12'h5a8, y[11:0]);
        bus(0, 4'h9, 0);
        chk(rdata_out, y[15:0]);
        $display("test bypass done");
        start(16'h0bb8, 16'h0001);
        wait_irq;
        g = (3000 - 200) * 1024 / (1800 - 200);
        repeat (2) @(posedge clock_in);
        #1 chk({15'h0, fault_out}, {15'h0, g > 1280});
        bus(0, 4'h6, 0);
        chk(rdata_out, {14'h0, g > 1280, 1'b1});
        $display("test fault done");
        finish_test;
    end
endmodule // adcc_top_tb_top
